// ---- inc/gmrex_pkg.sv ----
package gmrex_pkg;
    localparam int unsigned WORD_W      = 16;
    localparam int unsigned REG_CODE_W  = 3;
    localparam int unsigned ADDR_W      = 16;
    // register codes 2..6; the accumulator sits at code 7 for the pair
    localparam logic [2:0]  REG_CODE_MIN = 3'h2;
    localparam logic [2:0]  REG_CODE_MAX = 3'h6;
    localparam logic [2:0]  REG_CODE_EXT = 3'h6;
    localparam logic [2:0]  REG_CODE_ACC = 3'h7;
    localparam logic [2:0]  DOUBLE_COUNT = 3'h2;
    localparam logic [15:0] REG_RESET    = 16'h0000;

    typedef enum logic [3:0] {
        load_word_op        = 4'h0,
        store_word_op       = 4'h1,
        add_word_op         = 4'h2,
        subtract_word_op    = 4'h3,
        and_word_op         = 4'h4,
        compare_word_op     = 4'h5,
        load_multiple_op    = 4'h6,
        load_double_op      = 4'h7,
        store_multiple_op   = 4'h8,
        store_double_op     = 4'h9,
        double_add_op       = 4'ha,
        double_subtract_op  = 4'hb,
        compare_double_op   = 4'hc
    } gmrex_op_type;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_READ  = 3'b001,
        ST_WAIT  = 3'b011,
        ST_WRITE = 3'b010,
        ST_DONE  = 3'b110
    } gmrex_state_type;
endpackage : gmrex_pkg

// ---- core/gmrex_alu.sv ----
module gmrex_alu
    import gmrex_pkg::*;
#(
    parameter int unsigned W = 16
)(
    input  wire logic [W-1:0] i_reg,
    input  wire logic [W-1:0] i_mem,
    input  wire logic         i_sub,
    output logic      [W-1:0] o_sum,
    output logic              o_ovf,
    output logic              o_cry,
    output logic              o_eq,
    output logic              o_gt
);
    wire logic [W-1:0] opnd_b;
    wire logic [W:0]   inc_w;
    wire logic [W:0]   add_w;
    assign opnd_b = i_sub ? ~i_mem : i_mem;
    // increment carry kept separate: negating zero carries here
    assign inc_w  = {1'b0, opnd_b} + {{W{1'b0}}, i_sub};
    assign add_w  = {1'b0, i_reg} + {1'b0, inc_w[W-1:0]};
    assign o_sum  = add_w[W-1:0];
    assign o_cry  = add_w[W] | inc_w[W];
    assign o_ovf  = i_sub ? ((o_sum[W-1] == i_mem[W-1]) && (i_reg[W-1] != i_mem[W-1]))
                          : ((i_reg[W-1] == i_mem[W-1]) && (o_sum[W-1] != i_reg[W-1]));
    assign o_eq   = (i_reg == i_mem);
    assign o_gt   = $signed(i_reg) > $signed(i_mem);
endmodule : gmrex_alu

// ---- core/gmrex_exec.sv ----
// Summary of operation
// RQ1: store word writes selected register to memory
// RQ2: sequence holds interrupts off until finished
// RQ3: register select codes two through six only
// RQ4: add word sums memory into selected register
// RQ5: add sets overflow and carry, else clears
// RQ6: subtract adds negated memory word to register
// RQ7: subtract overflow from sign relationships
// RQ8: subtract carry from increment or add
// RQ9: logical and, indicators left alone
// RQ10: compare word signed, sets indicator pair
// RQ11: load multiple fills consecutive registers
// RQ12: count and start coded two through six
// RQ13: load double is count two from six
// RQ14: store multiple writes consecutive registers out
// RQ15: store double writes pair as doubleword
// RQ16: stores change only memory
// RQ17: double add on pair, add flag rules
// RQ18: double subtract negates doubleword and adds
// RQ19: double subtract flags like single subtract
// RQ20: compare double signed, sets indicator pair
// RQ21: load word copies memory into register
// RQ22: extended accumulator high, lower address
// RQ23: bad register codes raise unimplemented fault
module gmrex_exec
    import gmrex_pkg::*;
#(
    parameter int unsigned W  = 16,
    parameter int unsigned AW = 16
)(
    input  wire logic                      i_core_clk,
    input  wire logic                      i_rst_b,
    input  wire logic                      i_start,
    input  wire gmrex_pkg::gmrex_op_type   i_op,
    input  wire logic [2:0]                i_register_select_field,
    input  wire logic [2:0]                i_count_field,
    input  wire logic [2:0]                i_first_field,
    input  wire logic [AW-1:0]             i_eff_addr,
    input  wire logic [W-1:0]              i_mem_rdata,
    input  wire logic                      i_mem_ack,
    output logic                           o_busy,
    output logic                           o_int_block,
    output logic                           o_done,
    output logic                           o_unimpl_fault,
    output logic                           o_mem_req,
    output logic                           o_mem_we,
    output logic      [AW-1:0]             o_mem_addr,
    output logic      [W-1:0]              o_mem_wdata,
    output logic                           o_overflow,
    output logic                           o_carry,
    output logic      [W-1:0]              o_reg_l,
    output logic      [W-1:0]              o_reg_t,
    output logic      [W-1:0]              o_reg_x,
    output logic      [W-1:0]              o_reg_b,
    output logic      [W-1:0]              o_reg_e,
    output logic      [W-1:0]              o_reg_a
);
    import gmrex_pkg::*;

    function automatic logic code_ok(input logic [2:0] c);
        code_ok = (c >= REG_CODE_MIN) && (c <= REG_CODE_MAX);
    endfunction : code_ok

    function automatic logic uses_fields(input gmrex_op_type op);
        uses_fields = (op == load_multiple_op) || (op == store_multiple_op);
    endfunction : uses_fields

    // registers 2..7 held by index; 7 is the accumulator
    logic [W-1:0]         gr_q [2:7];
    gmrex_state_type      state_q;
    gmrex_op_type         op_q;
    logic [2:0]           reg_q;
    logic [2:0]           left_q;
    logic [AW-1:0]        addr_q;
    logic [W-1:0]         hi_q;
    logic [W-1:0]         rd_q;
    logic                 ovf_q;
    logic                 cry_q;
    logic                 done_q;
    logic                 fault_q;
    logic                 req_q;
    logic                 we_q;
    logic [W-1:0]         wdata_q;

    wire logic            is_single;
    wire logic            is_double_arith;
    wire logic            is_load_multi;
    wire logic            is_store;
    wire logic            start_ok;
    wire logic [2:0]      start_reg;
    wire logic [2:0]      start_cnt;
    wire logic [W-1:0]    sel_reg;
    wire logic [W-1:0]    s_sum;
    wire logic            s_ovf;
    wire logic            s_cry;
    wire logic            s_eq;
    wire logic            s_gt;
    wire logic [2*W-1:0]  pair_reg;
    wire logic [2*W-1:0]  pair_mem;
    wire logic [2*W-1:0]  d_sum;
    wire logic            d_ovf;
    wire logic            d_cry;
    wire logic            d_eq;
    wire logic            d_gt;
    wire logic            sub_sel;
    wire logic            last_word;

    assign is_single       = (i_op <= compare_word_op);
    assign is_double_arith = (i_op == double_add_op) || (i_op == double_subtract_op) ||
                             (i_op == compare_double_op);
    assign is_load_multi   = (op_q == load_multiple_op) || (op_q == load_double_op);
    assign is_store        = (op_q == store_word_op) || (op_q == store_multiple_op) ||
                             (op_q == store_double_op);
    // fixed-pair forms ignore the fields and use count two from six
    assign start_reg = (is_single) ? i_register_select_field :
                       uses_fields(i_op) ? i_first_field :
                       REG_CODE_EXT;                                                       // RQ13 RQ15
    assign start_cnt = (is_single) ? 3'h1 :
                       uses_fields(i_op) ? i_count_field :
                       DOUBLE_COUNT;
    assign start_ok  = is_single ? code_ok(i_register_select_field) :                     // RQ3 RQ23
                       uses_fields(i_op) ?
                       (code_ok(i_count_field) && code_ok(i_first_field)) :                // RQ12 RQ23
                       (i_op <= compare_double_op);

    assign sel_reg   = gr_q[reg_q];
    assign sub_sel   = (op_q == subtract_word_op) || (op_q == double_subtract_op) ||
                       (op_q == compare_word_op) || (op_q == compare_double_op);
    assign pair_reg  = {gr_q[REG_CODE_EXT], gr_q[REG_CODE_ACC]};                          // RQ22
    assign pair_mem  = {hi_q, rd_q};                                                      // RQ22
    assign last_word = (left_q == 3'h1);

    gmrex_alu #(.W(W)) u_single (
        .i_reg (sel_reg),
        .i_mem (rd_q),
        .i_sub (sub_sel),
        .o_sum (s_sum),
        .o_ovf (s_ovf),
        .o_cry (s_cry),
        .o_eq  (s_eq),
        .o_gt  (s_gt)
    );

    gmrex_alu #(.W(2*W)) u_double (
        .i_reg (pair_reg),
        .i_mem (pair_mem),
        .i_sub (sub_sel),
        .o_sum (d_sum),
        .o_ovf (d_ovf),
        .o_cry (d_cry),
        .o_eq  (d_eq),
        .o_gt  (d_gt)
    );

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_q <= ST_IDLE;
            op_q    <= load_word_op;
            reg_q   <= REG_CODE_MIN;
            left_q  <= 3'h0;
            addr_q  <= '0;
            hi_q    <= REG_RESET;
            rd_q    <= REG_RESET;
            done_q  <= 1'b0;
            fault_q <= 1'b0;
            req_q   <= 1'b0;
            we_q    <= 1'b0;
            wdata_q <= REG_RESET;
        end
        else
        begin
            done_q  <= 1'b0;
            fault_q <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (i_start && !start_ok)
                    begin
                        fault_q <= 1'b1;                                                  // RQ23
                        done_q  <= 1'b1;
                    end
                    else if (i_start)
                    begin
                        op_q    <= i_op;
                        reg_q   <= start_reg;
                        left_q  <= (is_double_arith) ? DOUBLE_COUNT : start_cnt;
                        addr_q  <= i_eff_addr;
                        state_q <= ST_READ;
                    end
                end
                ST_READ:
                begin
                    // one bus word per pass; stores write, everything else reads
                    req_q   <= 1'b1;
                    we_q    <= is_store;
                    wdata_q <= sel_reg;                                                   // RQ1 RQ14 RQ15
                    state_q <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (i_mem_ack)
                    begin
                        // read data stands only in the ack cycle, so catch it here
                        rd_q    <= i_mem_rdata;
                        req_q   <= 1'b0;
                        we_q    <= 1'b0;
                        state_q <= ST_WRITE;
                    end
                end
                ST_WRITE:
                begin
                    // first word of a pair is the high half at the lower address
                    if (!is_store && !is_load_multi && (op_q >= double_add_op) && !last_word)
                    begin
                        hi_q <= rd_q;                                                     // RQ22
                    end
                    if (last_word)
                    begin
                        state_q <= ST_DONE;
                    end
                    else
                    begin
                        left_q  <= left_q - 3'h1;
                        addr_q  <= addr_q + {{(AW-1){1'b0}}, 1'b1};
                        reg_q   <= reg_q + 3'h1;
                        state_q <= ST_READ;
                    end
                end
                ST_DONE:
                begin
                    done_q  <= 1'b1;
                    state_q <= ST_IDLE;
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // register write-back and indicators, written only at the end of a word
    wire logic wb_now;
    assign wb_now = (state_q == ST_WRITE);

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            for (int i = 2; i <= 7; i++)
            begin
                gr_q[i] <= REG_RESET;
            end
        end
        else if (wb_now)
        begin
            case (op_q)
                load_word_op:      gr_q[reg_q] <= rd_q;                                   // RQ21
                add_word_op, subtract_word_op:
                    gr_q[reg_q] <= s_sum;                                                 // RQ4 RQ6
                and_word_op:       gr_q[reg_q] <= sel_reg & rd_q;                         // RQ9
                load_multiple_op, load_double_op:
                    gr_q[reg_q] <= rd_q;                                                  // RQ11 RQ13
                double_add_op, double_subtract_op:
                begin
                    if (last_word)
                    begin
                        gr_q[REG_CODE_EXT] <= d_sum[2*W-1:W];                             // RQ17 RQ18
                        gr_q[REG_CODE_ACC] <= d_sum[W-1:0];
                    end
                end
                default:
                begin
                    // compares and stores leave the registers alone
                end
            endcase
        end
    end

    // indicators apart from the register file, so and-word and stores cannot reach them
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ovf_q <= 1'b0;
            cry_q <= 1'b0;
        end
        else if (wb_now)
        begin
            case (op_q)
                add_word_op, subtract_word_op:
                begin
                    ovf_q <= s_ovf;                                                       // RQ5 RQ7
                    cry_q <= s_cry;                                                       // RQ5 RQ8
                end
                compare_word_op:
                begin
                    ovf_q <= s_gt | s_eq;                                                 // RQ10
                    cry_q <= s_eq;                                                        // RQ10
                end
                double_add_op, double_subtract_op:
                begin
                    if (last_word)
                    begin
                        ovf_q <= d_ovf;                                                   // RQ17 RQ19
                        cry_q <= d_cry;                                                   // RQ19
                    end
                end
                compare_double_op:
                begin
                    if (last_word)
                    begin
                        ovf_q <= d_gt | d_eq;                                             // RQ20
                        cry_q <= d_eq;                                                    // RQ20
                    end
                end
                default:
                begin
                    ovf_q <= ovf_q;                                                       // RQ9 RQ16
                end
            endcase
        end
    end

    assign o_busy         = (state_q != ST_IDLE);
    assign o_int_block    = (state_q != ST_IDLE) | i_start;                               // RQ2
    assign o_done         = done_q;
    assign o_unimpl_fault = fault_q;
    assign o_mem_req      = req_q;
    assign o_mem_we       = we_q;
    assign o_mem_addr     = addr_q;
    assign o_mem_wdata    = wdata_q;
    assign o_overflow     = ovf_q;
    assign o_carry        = cry_q;
    assign o_reg_l        = gr_q[2];
    assign o_reg_t        = gr_q[3];
    assign o_reg_x        = gr_q[4];
    assign o_reg_b        = gr_q[5];
    assign o_reg_e        = gr_q[6];
    assign o_reg_a        = gr_q[7];
endmodule : gmrex_exec

// ---- verif/gmrex_mem_model.sv ----
module gmrex_mem_model (
    input  wire logic        i_core_clk,
    input  wire logic        i_slow,
    input  wire logic        i_req,
    input  wire logic        i_we,
    input  wire logic [15:0] i_addr,
    input  wire logic [15:0] i_wdata,
    output logic             o_ack,
    output logic      [15:0] o_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [0:65535];
    int          wait_q;
    initial
    begin
        o_ack = 1'b0;
        o_rdata = 16'h0000;
        wait_q = 0;
    end
    // data only valid with ack; toggled otherwise so stale reads show
    always @(posedge i_core_clk)
    begin
        o_rdata <= ~o_rdata;
        o_ack <= 1'b0;
        if (i_req && !o_ack && wait_q != 0)
            wait_q <= wait_q - 1;
        else if (i_req && !o_ack)
        begin
            o_ack <= 1'b1;
            o_rdata <= mem[i_addr];
            if (i_we)
                mem[i_addr] <= i_wdata;
            wait_q <= i_slow ? $urandom_range(3, 0) : 0;
        end
    end
endmodule : gmrex_mem_model

// ---- verif/gmrex_exec_properties.sv ----
module gmrex_props
    import gmrex_pkg::*;
#(
    parameter int unsigned W  = 16,
    parameter int unsigned AW = 16
)(
    input wire logic                    i_core_clk,
    input wire logic                    i_rst_b,
    input wire logic                    i_start,
    input wire gmrex_pkg::gmrex_op_type i_op,
    input wire logic [2:0]              i_register_select_field,
    input wire logic [AW-1:0]           i_eff_addr,
    input wire logic                    i_mem_ack,
    input wire logic                    o_busy,
    input wire logic                    o_int_block,
    input wire logic                    o_done,
    input wire logic                    o_unimpl_fault,
    input wire logic                    o_mem_req,
    input wire logic                    o_mem_we,
    input wire logic [AW-1:0]           o_mem_addr,
    input wire logic [W-1:0]            o_mem_wdata,
    input wire logic                    o_overflow,
    input wire logic                    o_carry,
    input wire logic [W-1:0]            o_reg_l,
    input wire logic [W-1:0]            o_reg_e,
    input wire logic [W-1:0]            o_reg_a
);
    timeunit 1ns;
    timeprecision 1ns;
    gmrex_op_type op_q;
    logic         take;
    logic         sel_bad;
    assign take = i_start && !o_busy;
    assign sel_bad = i_register_select_field < REG_CODE_MIN || i_register_select_field > REG_CODE_MAX;
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            op_q <= load_word_op;
        else if (take)
            op_q <= i_op;
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    int_hold_a: assert property ((o_busy || take) |-> o_int_block)
        else $error("interrupt hold low during sequence");
    code_fault_a: assert property (take && i_op <= compare_word_op && sel_bad |=> o_done && o_unimpl_fault)
        else $error("bad register code not faulted");
    fault_quiet_a: assert property (o_unimpl_fault |-> o_done && !o_mem_req)
        else $error("fault without done or with memory cycle");
    add_read_a: assert property (take && i_op == add_word_op && !sel_bad
        |-> ##2 o_mem_req && !o_mem_we && o_mem_addr == $past(i_eff_addr, 2))
        else $error("add word read cycle wrong");
    store_write_a: assert property (take && i_op == store_word_op && !sel_bad
        |-> ##2 o_mem_req && o_mem_we && o_mem_addr == $past(i_eff_addr, 2))
        else $error("store word write cycle wrong");
    req_hold_a: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_wdata))
        else $error("memory request changed before ack");
    req_drop_a: assert property (o_mem_req && i_mem_ack |=> !o_mem_req)
        else $error("memory request held after ack");
    store_keep_a: assert property (o_mem_req && o_mem_we |=> $stable({o_overflow, o_carry, o_reg_e, o_reg_a}))
        else $error("store changed register or indicator");
    and_flags_a: assert property (o_busy && op_q == and_word_op |=> $stable({o_overflow, o_carry}))
        else $error("logical and changed indicators");
    cmp_keep_a: assert property (o_busy && op_q == compare_word_op |=> $stable({o_reg_l, o_reg_e}))
        else $error("compare changed a register");
    single_done_a: assert property (o_mem_req && i_mem_ack && op_q <= compare_word_op |-> ##3 o_done)
        else $error("done late after single word");
endmodule : gmrex_props

// ---- verif/test_gmrex_exec.sv ----
module test_gmrex_exec
    import gmrex_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic         core_clk = 1'b0;
    logic         rst_b = 1'b0;
    logic         start = 1'b0;
    logic         slow = 1'b0;
    gmrex_op_type op = load_word_op;
    logic [2:0]   sel = 3'h2;
    logic [2:0]   cnt = 3'h2;
    logic [2:0]   first = 3'h6;
    logic [15:0]  ea = 16'h0100;
    logic         ack, done, fault, req, we, ovf, cry, eo, ec;
    logic [15:0]  rdata, addr, wdata;
    wire logic [15:0] r [2:7];
    logic [15:0]  er [2:7] = '{default: REG_RESET};
    logic [15:0]  em [0:15];
    int           bad_count = 0;
    int           checked = 0;
    int           cycles = 0;
    gmrex_exec #(.W(16), .AW(16)) gmrex_exec_inst (.i_core_clk(core_clk), .i_rst_b(rst_b), .i_start(start),
        .i_op(op), .i_register_select_field(sel), .i_count_field(cnt), .i_first_field(first), .i_eff_addr(ea),
        .i_mem_rdata(rdata), .i_mem_ack(ack), .o_busy(), .o_int_block(), .o_done(done), .o_unimpl_fault(fault),
        .o_mem_req(req), .o_mem_we(we), .o_mem_addr(addr), .o_mem_wdata(wdata), .o_overflow(ovf), .o_carry(cry),
        .o_reg_l(r[2]), .o_reg_t(r[3]), .o_reg_x(r[4]), .o_reg_b(r[5]), .o_reg_e(r[6]), .o_reg_a(r[7]));
    gmrex_mem_model gmrex_mem_model_inst (.i_core_clk(core_clk), .i_slow(slow), .i_req(req), .i_we(we),
        .i_addr(addr), .i_wdata(wdata), .o_ack(ack), .o_rdata(rdata));
    task automatic give_verdict;
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_flag(input logic [1:0] got, input logic [1:0] exp);
        chk_word({14'h0000, got}, {14'h0000, exp});
    endtask : chk_flag
    function automatic logic [33:0] arith(input logic [31:0] x, input logic [31:0] m, input logic sub);
        logic [32:0] s;
        s = {1'b0, x} + (sub ? {1'b0, ~m} + 33'h1 : {1'b0, m});
        return {sub ? x[31] != m[31] && s[31] == m[31] : x[31] == m[31] && s[31] != x[31], s};
    endfunction : arith
    function automatic logic [1:0] cmp(input logic [31:0] x, input logic [31:0] m);
        return ($signed(x) > $signed(m)) ? 2'b10 : (x == m ? 2'b11 : 2'b00);
    endfunction : cmp
    task automatic setm(input int k, input logic [15:0] v);
        em[k] = v;
        gmrex_mem_model_inst.mem[16'h0100 + k] = v;
    endtask : setm
    // expected state; doubleword high half sits at the lower address
    task automatic predict(input gmrex_op_type o, input logic [2:0] s, c, f, input int k);
        logic [33:0] q;
        q = arith({er[6], er[7]}, {em[k], em[k + 1]}, o == double_subtract_op);
        case (o)
            load_word_op: er[s] = em[k];
            store_word_op: em[k] = er[s];
            add_word_op, subtract_word_op: {eo, ec, er[s]} = arith({er[s], 16'h0000}, {em[k], 16'h0000},
                o == subtract_word_op) >> 16;
            and_word_op: er[s] = er[s] & em[k];
            compare_word_op: {eo, ec} = cmp({er[s], 16'h0000}, {em[k], 16'h0000});
            load_multiple_op, load_double_op: for (int i = 0; i < c; i++) er[f + i] = em[k + i];
            store_multiple_op, store_double_op: for (int i = 0; i < c; i++) em[k + i] = er[f + i];
            double_add_op, double_subtract_op: {eo, ec, er[6], er[7]} = q;
            default: {eo, ec} = cmp({er[6], er[7]}, {em[k], em[k + 1]});
        endcase
    endtask : predict
    task automatic run_op(input gmrex_op_type o, input logic [2:0] s, c, f, input logic [15:0] a);
        logic bad;
        int   n;
        bad = (o <= compare_word_op && (s < REG_CODE_MIN || s > REG_CODE_MAX))
            || ((o == load_multiple_op || o == store_multiple_op) && (c < 2 || c > 6 || f < 2 || f > 6));
        @(posedge core_clk);
        op <= o;
        sel <= s;
        cnt <= c;
        first <= f;
        ea <= a;
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        #1;
        n = 0;
        while (done !== 1'b1 && n < 100)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk_flag({fault, done}, {bad, 1'b1});
        if (!bad)
            predict(o, s, c, f, a - 16'h0100);
        chk_flag({ovf, cry}, {eo, ec});
        for (int i = 2; i < 8; i++) chk_word(r[i], er[i]);
        for (int i = 0; i < 16; i++) chk_word(gmrex_mem_model_inst.mem[16'h0100 + i], em[i]);
    endtask : run_op
    gmrex_op_type cop [9] = '{add_word_op, add_word_op, subtract_word_op, subtract_word_op, subtract_word_op,
        compare_word_op, compare_word_op, compare_word_op, and_word_op};
    logic [15:0] creg [9] = '{16'h7fff, 16'hffff, 16'h1234, 16'h8000, 16'h0005, 16'h0005, 16'h8000, 16'h0001, 16'hf0f0};
    logic [15:0] cmem [9] = '{16'h0001, 16'h0001, 16'h0000, 16'h0001, 16'h0005, 16'h0005, 16'h0001, 16'hffff, 16'h3c3c};
    initial
    begin
        forever #20 core_clk = ~core_clk;
    end
    // hang guard, far above the expected run length
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            give_verdict();
        end
    end
    initial
    begin
        gmrex_op_type o;
        logic [2:0]   s, c, f;
        eo = 1'b0;
        ec = 1'b0;
        void'($urandom(32'h0000_6f1a));
        for (int i = 0; i < 16; i++) setm(i, 16'($urandom()));
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        run_op(load_multiple_op, 3'h2, 3'h6, 3'h2, 16'h0100);
        for (int i = 0; i < 13; i++) run_op(gmrex_op_type'(i), 3'h6, DOUBLE_COUNT, REG_CODE_EXT, 16'h0102);
        for (int i = 0; i < 3; i++) run_op(load_word_op, 3'(i == 2 ? 7 : i), 3'h2, 3'h2, 16'h0100);
        run_op(store_multiple_op, 3'h2, 3'h7, 3'h2, 16'h0100);
        for (int i = 0; i < 9; i++)
        begin
            setm(8, creg[i]);
            setm(9, cmem[i]);
            run_op(load_word_op, 3'(2 + i % 5), 3'h2, 3'h2, 16'h0108);
            run_op(cop[i], 3'(2 + i % 5), 3'h2, 3'h2, 16'h0109);
        end
        for (int t = 0; t < 60; t++)
        begin
            o = gmrex_op_type'($urandom_range(12, 0));
            f = 3'($urandom_range(6, 2));
            c = 3'($urandom_range(8 - f > 6 ? 6 : 8 - f, 2));
            s = ($urandom_range(3, 0) == 0) ? 3'($urandom_range(7, 0)) : 3'($urandom_range(6, 2));
            if ($urandom_range(9, 0) == 0)
                c = 3'h7;
            if (o == load_double_op || o == store_double_op || o >= double_add_op)
            begin
                c = DOUBLE_COUNT;
                f = REG_CODE_EXT;
            end
            slow <= 1'($urandom_range(1, 0));
            run_op(o, s, c, f, 16'h0100 + 16'($urandom_range(7, 0)));
        end
        give_verdict();
    end
endmodule : test_gmrex_exec
bind gmrex_exec gmrex_props #(.W(W), .AW(AW)) gmrex_props_inst (
    .i_core_clk, .i_rst_b, .i_start, .i_op, .i_register_select_field, .i_eff_addr, .i_mem_ack,
    .o_busy, .o_int_block, .o_done, .o_unimpl_fault, .o_mem_req, .o_mem_we, .o_mem_addr,
    .o_mem_wdata, .o_overflow, .o_carry, .o_reg_l, .o_reg_e, .o_reg_a
);
